// File: acr_pkg.sv
// Operation
// - offset high word holds offset bits 23..8
// - offset low word upper byte holds bits 7..0
// - gain high word holds unsigned gain bits 23..8
// - gain low word upper byte holds bits 7..0
// - gain resets to 8000h high, zero low
// - low byte of low words reads zero
// - config bits 15..6 hold signed phase delay
// - config bits 5..3 reserved, read zero, unwritable
// - bit 2 bypasses filter, else global setting
// - bits 1..0 select channel input source
// - config and offsets reset to zero
`default_nettype none
package acr_pkg;

	// ****************************************
	// bus widths
	// ****************************************
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned STRB_W   = DATA_W / 8;
	localparam int unsigned REG_W    = 16;
	localparam int unsigned NUM_REGS = 7;
	localparam int unsigned IDX_W    = 6;

	typedef logic [REG_W-1:0] acr_word_t;
	typedef logic [2:0]       acr_slot_t;

	// ****************************************
	// register indices, byte address = 4 * index
	// ****************************************
	localparam logic [IDX_W-1:0] IDX_CH1_OFFSET_CAL_HIGH = 6'h0f;
	localparam logic [IDX_W-1:0] IDX_CH1_OFFSET_CAL_LOW  = 6'h10;
	localparam logic [IDX_W-1:0] IDX_CH1_GAIN_CAL_HIGH   = 6'h11;
	localparam logic [IDX_W-1:0] IDX_CH1_GAIN_CAL_LOW    = 6'h12;
	localparam logic [IDX_W-1:0] IDX_CH2_CONFIG          = 6'h13;
	localparam logic [IDX_W-1:0] IDX_CH2_OFFSET_CAL_HIGH = 6'h14;
	localparam logic [IDX_W-1:0] IDX_CH2_OFFSET_CAL_LOW  = 6'h15;
	localparam logic [IDX_W-1:0] IDX_STATUS              = 6'h20;
	localparam logic [1:0]       ADDR_LSB_W              = 2'h0;

	// storage slots
	localparam acr_slot_t SLOT_CH1_OFS_HI = 3'h0;
	localparam acr_slot_t SLOT_CH1_OFS_LO = 3'h1;
	localparam acr_slot_t SLOT_CH1_GAIN_HI = 3'h2;
	localparam acr_slot_t SLOT_CH1_GAIN_LO = 3'h3;
	localparam acr_slot_t SLOT_CH2_CONFIG    = 3'h4;
	localparam acr_slot_t SLOT_CH2_OFS_HI = 3'h5;
	localparam acr_slot_t SLOT_CH2_OFS_LO = 3'h6;

	// ****************************************
	// writable masks and reset values
	// ****************************************
	localparam acr_word_t MASK_HIGH_WORD = 16'hffff;
	localparam acr_word_t MASK_LOW_WORD  = 16'hff00;
	localparam acr_word_t MASK_CONFIG    = 16'hffc7;
	localparam acr_word_t RST_ZERO       = 16'h0000;
	localparam acr_word_t RST_GAIN_HIGH  = 16'h8000;

	// config fields
	localparam int unsigned CFG_PHASE_MSB  = 15;
	localparam int unsigned CFG_PHASE_LSB  = 6;
	localparam int unsigned CFG_BYPASS_BIT = 2;
	localparam int unsigned CFG_MUX_MSB    = 1;
	localparam int unsigned CFG_MUX_LSB    = 0;
	localparam int unsigned LOW_BYTE_MSB   = 15;
	localparam int unsigned LOW_BYTE_LSB   = 8;

	// input selector codes
	localparam logic [1:0] MUX_NORMAL   = 2'h0;
	localparam logic [1:0] MUX_SHORTED  = 2'h1;
	localparam logic [1:0] MUX_TEST_POS = 2'h2;
	localparam logic [1:0] MUX_TEST_NEG = 2'h3;

	// status fields
	localparam int unsigned STAT_FILT_EN_BIT = 0;
	localparam int unsigned STAT_GLOBAL_BIT  = 1;

	// responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// File: acr_calib_regs.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module acr_calib_regs (
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire logic [acr_pkg::ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic [2:0]                      s_axi_awprot,
	input  wire logic                            s_axi_awvalid,
	output var  logic                            s_axi_awready,
	input  wire logic [acr_pkg::DATA_W-1:0]      s_axi_wdata,
	input  wire logic [acr_pkg::STRB_W-1:0]      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output var  logic                            s_axi_wready,
	output var  logic [1:0]                      s_axi_bresp,
	output var  logic                            s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [acr_pkg::ADDR_W-1:0]      s_axi_araddr,
	input  wire logic [2:0]                      s_axi_arprot,
	input  wire logic                            s_axi_arvalid,
	output var  logic                            s_axi_arready,
	output var  logic [acr_pkg::DATA_W-1:0]      s_axi_rdata,
	output var  logic [1:0]                      s_axi_rresp,
	output var  logic                            s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	input  wire logic                            global_dc_filter_setting,
	output var  logic [23:0]                     ch1_offset_correction,
	output var  logic [23:0]                     ch1_gain_factor,
	output var  logic [23:0]                     ch2_offset_correction,
	output var  logic [9:0]                      ch2_phase_delay,
	output var  logic                            ch2_dc_filter_bypass,
	output var  logic                            ch2_dc_filter_enable,
	output var  logic [1:0]                      ch2_input_select
);
	import acr_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] addr);
		logic [IDX_W-1:0] idx;
		logic             hit;
		acr_slot_t        slot;
		idx  = addr[ADDR_W-1:2];
		hit  = 1'h1;
		slot = SLOT_CH1_OFS_HI;
		if (idx == IDX_CH1_OFFSET_CAL_HIGH) begin
			slot = SLOT_CH1_OFS_HI;
		end else if (idx == IDX_CH1_OFFSET_CAL_LOW) begin
			slot = SLOT_CH1_OFS_LO;
		end else if (idx == IDX_CH1_GAIN_CAL_HIGH) begin
			slot = SLOT_CH1_GAIN_HI;
		end else if (idx == IDX_CH1_GAIN_CAL_LOW) begin
			slot = SLOT_CH1_GAIN_LO;
		end else if (idx == IDX_CH2_CONFIG) begin
			slot = SLOT_CH2_CONFIG;
		end else if (idx == IDX_CH2_OFFSET_CAL_HIGH) begin
			slot = SLOT_CH2_OFS_HI;
		end else if (idx == IDX_CH2_OFFSET_CAL_LOW) begin
			slot = SLOT_CH2_OFS_LO;
		end else begin
			hit = 1'h0;
		end
		if (addr[1:0] != ADDR_LSB_W) begin
			hit = 1'h0;
		end
		return {hit, IDX_W'(slot)};
	endfunction

	function automatic acr_word_t slot_mask(input acr_slot_t slot);
		acr_word_t m;
		m = MASK_HIGH_WORD;
		case (slot)
			SLOT_CH1_OFS_LO, SLOT_CH1_GAIN_LO, SLOT_CH2_OFS_LO: m = MASK_LOW_WORD;
			SLOT_CH2_CONFIG: m = MASK_CONFIG;
			default: m = MASK_HIGH_WORD;
		endcase
		return m;
	endfunction

	function automatic acr_word_t slot_reset(input acr_slot_t slot);
		acr_word_t r;
		r = RST_ZERO;
		if (slot == SLOT_CH1_GAIN_HI) begin
			r = RST_GAIN_HIGH;
		end
		return r;
	endfunction

	// ****************************************
	// write channel state
	// ****************************************
	logic                   aw_held_q, aw_held_d;
	logic                   w_held_q, w_held_d;
	logic [ADDR_W-1:0]      waddr_q, waddr_d;
	logic [REG_W-1:0]       wdata_q, wdata_d;
	logic [1:0]             wstrb_q, wstrb_d;
	logic                   awready_q, awready_d;
	logic                   wready_q, wready_d;
	logic                   bvalid_q, bvalid_d;
	logic [1:0]             bresp_q, bresp_d;
	logic                   do_write;
	logic [IDX_W:0]         wdec;
	acr_word_t              regs_q [NUM_REGS];
	acr_word_t              regs_d [NUM_REGS];

	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		waddr_d   = waddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		wdec      = decode(waddr_q);
		do_write  = aw_held_q && w_held_q && !bvalid_q;
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'h1;
			waddr_d   = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'h1;
			wdata_d  = s_axi_wdata[REG_W-1:0];
			wstrb_d  = s_axi_wstrb[1:0];
		end
		if (do_write) begin
			aw_held_d = 1'h0;
			w_held_d  = 1'h0;
			bvalid_d  = 1'h1;
			bresp_d   = wdec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'h0;
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d  = !w_held_d && !bvalid_d;
	end

	always_comb begin
		acr_word_t m;
		m = RST_ZERO;
		for (int i = 0; i < NUM_REGS; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (do_write && wdec[IDX_W]) begin
			m = slot_mask(acr_slot_t'(wdec[2:0])) & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
			regs_d[wdec[2:0]] = (regs_q[wdec[2:0]] & ~m) | (wdata_q & m);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'h0;
			w_held_q  <= 1'h0;
			waddr_q   <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			awready_q <= 1'h0;
			wready_q  <= 1'h0;
			bvalid_q  <= 1'h0;
			bresp_q   <= RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			waddr_q   <= waddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ****************************************
	// register file
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= slot_reset(acr_slot_t'(i));
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= regs_d[i];
			end
		end
	end

	// ****************************************
	// filter enable and status
	// ****************************************
	logic filt_en_q, filt_en_d;
	logic global_q, global_d;

	always_comb begin
		global_d  = global_dc_filter_setting;
		filt_en_d = regs_q[SLOT_CH2_CONFIG][CFG_BYPASS_BIT] ? 1'h0 : global_dc_filter_setting;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			filt_en_q <= 1'h0;
			global_q  <= 1'h0;
		end else begin
			filt_en_q <= filt_en_d;
			global_q  <= global_d;
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	logic                   arready_q, arready_d;
	logic                   rvalid_q, rvalid_d;
	logic [DATA_W-1:0]      rdata_q, rdata_d;
	logic [1:0]             rresp_q, rresp_d;
	logic [IDX_W:0]         rdec;

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		rdec     = decode(s_axi_araddr);
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'h1;
			rdata_d  = '0;
			rresp_d  = RESP_SLVERR;
			if (rdec[IDX_W]) begin
				rdata_d[REG_W-1:0] = regs_q[rdec[2:0]] & slot_mask(acr_slot_t'(rdec[2:0]));
				rresp_d            = RESP_OKAY;
			end else if (s_axi_araddr[ADDR_W-1:2] == IDX_STATUS && s_axi_araddr[1:0] == ADDR_LSB_W) begin
				rdata_d[STAT_FILT_EN_BIT] = filt_en_q;
				rdata_d[STAT_GLOBAL_BIT]  = global_q;
				rresp_d                   = RESP_OKAY;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'h0;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'h0;
			rvalid_q  <= 1'h0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign ch1_offset_correction = {regs_q[SLOT_CH1_OFS_HI], regs_q[SLOT_CH1_OFS_LO][LOW_BYTE_MSB:LOW_BYTE_LSB]};
	assign ch1_gain_factor       = {regs_q[SLOT_CH1_GAIN_HI], regs_q[SLOT_CH1_GAIN_LO][LOW_BYTE_MSB:LOW_BYTE_LSB]};
	assign ch2_offset_correction = {regs_q[SLOT_CH2_OFS_HI], regs_q[SLOT_CH2_OFS_LO][LOW_BYTE_MSB:LOW_BYTE_LSB]};
	assign ch2_phase_delay       = regs_q[SLOT_CH2_CONFIG][CFG_PHASE_MSB:CFG_PHASE_LSB];
	assign ch2_dc_filter_bypass  = regs_q[SLOT_CH2_CONFIG][CFG_BYPASS_BIT];
	assign ch2_dc_filter_enable  = filt_en_q;
	assign ch2_input_select      = regs_q[SLOT_CH2_CONFIG][CFG_MUX_MSB:CFG_MUX_LSB];

endmodule // acr_calib_regs
`default_nettype wire

// File: acr_calib_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module acr_calib_regs_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        global_dc_filter_setting,
	input wire logic [23:0] ch1_gain_factor,
	input wire logic [9:0]  ch2_phase_delay,
	input wire logic        ch2_dc_filter_bypass,
	input wire logic        ch2_dc_filter_enable,
	input wire logic [1:0]  ch2_input_select
);
	// ****************************************
	// handshake steps
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read data late");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("read data dropped");
	a_gain_reset: assert property (!$past(aresetn) |-> ch1_gain_factor == 24'h800000)
		else $error("gain reset value wrong");
	a_cfg_reset: assert property (!$past(aresetn) |-> {ch2_phase_delay, ch2_dc_filter_bypass, ch2_input_select} == 13'h0)
		else $error("config reset value wrong");
	a_filter_follow: assert property ($past(aresetn) |->
		ch2_dc_filter_enable == (!$past(ch2_dc_filter_bypass) && $past(global_dc_filter_setting)))
		else $error("filter enable wrong");
	a_cfg_by_write: assert property ($past(aresetn) &&
		$changed({ch2_phase_delay, ch2_dc_filter_bypass, ch2_input_select}) |-> $rose(s_axi_bvalid))
		else $error("config changed without write");
	a_gain_by_write: assert property ($past(aresetn) && $changed(ch1_gain_factor) |-> $rose(s_axi_bvalid))
		else $error("gain changed without write");
endmodule // acr_calib_regs_chk
`default_nettype wire

// File: test_acr_calib_regs.sv
`timescale 1ns/10ps
`default_nettype none
module test_acr_calib_regs;
	import acr_pkg::*;
	logic        aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, global_dc_filter_setting = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ch2_input_select;
	logic [23:0] ch1_offset_correction, ch1_gain_factor, ch2_offset_correction;
	logic [9:0]  ch2_phase_delay;
	logic        ch2_dc_filter_bypass, ch2_dc_filter_enable;
	int          err_total = 0;
	int          n_checks = 0;

	acr_calib_regs i_dut (.*);

	// ****************************************
	// compare, verdict, bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 40);
		s_axi_bready <= 1'h0;
		if (n >= 40) begin
			err_total++;
			close_out();
		end
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 40);
		s_axi_rready <= 1'h0;
		if (n >= 40) begin
			err_total++;
			close_out();
		end
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	function automatic logic [31:0] msk(input int i);
		case (i)
			16, 18, 21: msk = 32'hff00;
			19: msk = 32'hffc7;
			default: msk = 32'hffff;
		endcase
	endfunction

	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 15; i <= 21; i++)
			rd(8'(i * 4), (i == 17) ? 32'h8000 : 32'h0, RESP_OKAY);
		for (int i = 15; i <= 21; i++)
			wr(8'(i * 4), {16'hffff, 8'(i), 8'hff}, 4'hf, RESP_OKAY);
		for (int i = 15; i <= 21; i++)
			rd(8'(i * 4), {16'h0, 8'(i), 8'hff} & msk(i), RESP_OKAY);
		chk(32'(ch1_offset_correction), 32'h0fff10);
		chk(32'(ch1_gain_factor), 32'h11ff12);
		chk(32'(ch2_offset_correction), 32'h14ff15);
		chk(32'({ch2_phase_delay, ch2_dc_filter_bypass, ch2_input_select}), 32'h27f);
		wr(8'h4c, 32'h0, 4'h1, RESP_OKAY);
		rd(8'h4c, 32'h1300, RESP_OKAY);
		for (int c = 0; c < 4; c++) begin
			wr(8'h4c, 32'(c), 4'h3, RESP_OKAY);
			chk(32'(ch2_input_select), 32'(c));
		end
		global_dc_filter_setting <= 1'h1;
		repeat (3) @(posedge aclk);
		chk(32'(ch2_dc_filter_enable), 32'h1);
		rd(8'h80, 32'h3, RESP_OKAY);
		wr(8'h4c, 32'h4, 4'h3, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(32'(ch2_dc_filter_enable), 32'h0);
		rd(8'h80, 32'h2, RESP_OKAY);
		rd(8'h58, 32'h0, RESP_SLVERR);
		wr(8'h3d, 32'h0, 4'hf, RESP_SLVERR);
		wr(8'h80, 32'h0, 4'hf, RESP_SLVERR);
		rd(8'h3c, 32'h0fff, RESP_OKAY);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(8'h44, 32'h8000, RESP_OKAY);
		rd(8'h4c, 32'h0, RESP_OKAY);
		close_out();
	end
endmodule // test_acr_calib_regs

bind acr_calib_regs acr_calib_regs_chk i_chk (.*);
`default_nettype wire
